// ---- src/rlt_pkg.sv ----
package rlt_pkg;
  // register addresses on the special-function-register bus
  localparam logic [7:0] RLT_ADDR_CTRL = 8'hc8;
  localparam logic [7:0] RLT_ADDR_RELOAD_LO = 8'hca;
  localparam logic [7:0] RLT_ADDR_RELOAD_HI = 8'hcb;
  localparam logic [7:0] RLT_ADDR_COUNT_LO = 8'hcc;
  localparam logic [7:0] RLT_ADDR_COUNT_HI = 8'hcd;

  // control register field positions
  localparam int RLT_BIT_HIGH_FLAG = 7;
  localparam int RLT_BIT_LOW_FLAG = 6;
  localparam int RLT_BIT_LOW_IRQ_EN = 5;
  localparam int RLT_BIT_CAPTURE_EN = 4;
  localparam int RLT_BIT_SPLIT = 3;
  localparam int RLT_BIT_RUN = 2;
  localparam int RLT_BIT_EXT_SEL = 0;

  // reset values
  localparam logic [7:0] RLT_CTRL_RESET = 8'h00;
  localparam logic [7:0] RLT_BYTE_RESET = 8'h00;

  // byte and word wrap points
  localparam logic [7:0] RLT_BYTE_MAX = 8'hff;
  localparam logic [15:0] RLT_WORD_MAX = 16'hffff;

  // prescaler divisions
  localparam logic [3:0] RLT_SYS_DIV = 4'hc;
  localparam logic [2:0] RLT_EXT_DIV_LAST = 3'h7;
endpackage

// ---- src/rlt_tick_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface rlt_tick_if;
  logic tick_sys12;
  logic tick_ext8;
  logic lfo_fall;
  modport src (output tick_sys12, output tick_ext8, output lfo_fall);
  modport snk (input tick_sys12, input tick_ext8, input lfo_fall);
endinterface
`default_nettype wire

// ---- src/rlt_tick_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module rlt_tick_gen
  import rlt_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic ext_clk, // external oscillator
  input wire logic lfo_out, // low-frequency oscillator output
  rlt_tick_if.src ticks // one-cycle count enables
);
  logic [3:0] div12_q, div12_d;
  logic [2:0] ext_sync_q, ext_sync_d;
  logic [2:0] ext_div_q, ext_div_d;
  logic [2:0] lfo_sync_q, lfo_sync_d;
  logic sys12_q, sys12_d;
  logic ext8_q, ext8_d;
  logic fall_q, fall_d;

  always_comb begin
    div12_d = div12_q + 4'h1;
    sys12_d = 1'b0;
    if (div12_q == RLT_SYS_DIV - 4'h1) begin
      div12_d = 4'h0;
      sys12_d = 1'b1;
    end
    ext_sync_d = {ext_sync_q[1:0], ext_clk};
    ext_div_d = ext_div_q;
    ext8_d = 1'b0;
    // only the second and third stages feed the edge detect
    if (ext_sync_q[1] && !ext_sync_q[2]) begin
      ext_div_d = ext_div_q + 3'h1;
      ext8_d = (ext_div_q == RLT_EXT_DIV_LAST);
    end
    lfo_sync_d = {lfo_sync_q[1:0], lfo_out};
    fall_d = lfo_sync_q[2] && !lfo_sync_q[1];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div12_q <= 4'h0;
      ext_sync_q <= 3'h0;
      ext_div_q <= 3'h0;
      lfo_sync_q <= 3'h0;
      sys12_q <= 1'b0;
      ext8_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      div12_q <= div12_d;
      ext_sync_q <= ext_sync_d;
      ext_div_q <= ext_div_d;
      lfo_sync_q <= lfo_sync_d;
      sys12_q <= sys12_d;
      ext8_q <= ext8_d;
      fall_q <= fall_d;
    end
  end

  assign ticks.tick_sys12 = sys12_q;
  assign ticks.tick_ext8 = ext8_q;
  assign ticks.lfo_fall = fall_q;
endmodule
`default_nettype wire

// ---- src/rlt_timer.sv ----
// Summary of operation
// - 16-bit mode counts one word; on 0xFFFF wrap loads reload pair, sets high flag.
// - 16-bit mode with interrupt enabled requests an interrupt on every word overflow.
// - 16-bit mode plus low-byte enable also interrupts on each low-byte wrap.
// - split mode runs two 8-bit counters, each reloading from its own reload byte.
// - split mode: run control gates only the high counter; low always counts.
// - split mode: each byte's select picks system clock or the shared prescaled source.
// - low-byte select clocks whole timer in 16-bit mode, low counter in split.
// - high-byte select matters only in split mode.
// - external clock over eight is synchronised to the system clock first.
// - external select picks system clock over 12 or external clock over 8.
// - high flag sets whenever the high byte overflows from 0xFF and loads its reload byte.
// - low flag sets whenever the low byte wraps, in both modes.
// - split mode interrupts on high overflow, and on either with low enable.
// - hardware never clears the overflow flags; software clears them by writing.
// - capture with interrupt enabled copies count into reload pair on oscillator fall.
// - split bit selects 16-bit mode at 0 and two 8-bit counters at 1.
// - run bit stops counting at 0, allows it at 1; gates whole 16-bit counter, only the high counter in split mode.
// - control bit 1 reads zero and ignores writes.
// - low interrupt enable gates low-byte requests; the low flag sets regardless.
`timescale 1ns/1ps
`default_nettype none
module rlt_timer
  import rlt_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] sfr_addr, // register address
  input wire logic sfr_wr, // write strobe, one cycle
  input wire logic sfr_rd, // read strobe, one cycle
  input wire logic [7:0] sfr_wdata, // write data
  output logic [7:0] sfr_rdata, // read data, next cycle
  input wire logic timer_irq_enable, // timer interrupt enable from core
  input wire logic high_byte_clock_select, // high byte uses system clock
  input wire logic low_byte_clock_select, // low byte uses system clock
  input wire logic ext_clk, // external oscillator
  input wire logic lfo_out, // low-frequency oscillator output
  output logic timer_irq // interrupt request level
);
  rlt_tick_if ticks ();

  rlt_tick_gen u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ext_clk(ext_clk),
    .lfo_out(lfo_out),
    .ticks(ticks.src)
  );

  logic high_flag_q, high_flag_d;
  logic low_flag_q, low_flag_d;
  logic low_irq_en_q, low_irq_en_d;
  logic capture_en_q, capture_en_d;
  logic split_q, split_d;
  logic run_q, run_d;
  logic ext_sel_q, ext_sel_d;
  logic [7:0] count_lo_q, count_lo_d;
  logic [7:0] count_hi_q, count_hi_d;
  logic [7:0] reload_lo_q, reload_lo_d;
  logic [7:0] reload_hi_q, reload_hi_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic step_lo, step_hi, wrap_lo, wrap_hi, capture;
  logic [15:0] count_word;
  logic [7:0] ctrl_view;

  function automatic logic pick_tick(input logic use_sys, input logic ext_sel,
                                     input logic tick_sys12, input logic tick_ext8);
    logic t;
    t = ext_sel ? tick_ext8 : tick_sys12;
    pick_tick = use_sys ? 1'b1 : t;
  endfunction

  assign count_word = {count_hi_q, count_lo_q};

  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[RLT_BIT_HIGH_FLAG] = high_flag_q;
    ctrl_view[RLT_BIT_LOW_FLAG] = low_flag_q;
    ctrl_view[RLT_BIT_LOW_IRQ_EN] = low_irq_en_q;
    ctrl_view[RLT_BIT_CAPTURE_EN] = capture_en_q;
    ctrl_view[RLT_BIT_SPLIT] = split_q;
    ctrl_view[RLT_BIT_RUN] = run_q;
    ctrl_view[RLT_BIT_EXT_SEL] = ext_sel_q;
  end

  // count enables
  always_comb begin
    // low select clocks the whole word in 16-bit mode
    step_lo = pick_tick(low_byte_clock_select, ext_sel_q, ticks.tick_sys12, ticks.tick_ext8);
    // high select only in split mode
    step_hi = pick_tick(high_byte_clock_select, ext_sel_q, ticks.tick_sys12, ticks.tick_ext8);
    if (split_q) begin
      // low byte free-running in split mode
      step_hi = step_hi && run_q;
    end else begin
      step_lo = step_lo && run_q;
      // high byte carries from low wrap
      step_hi = step_lo && (count_lo_q == RLT_BYTE_MAX);
    end
    wrap_lo = step_lo && (count_lo_q == RLT_BYTE_MAX);
    wrap_hi = step_hi && (count_hi_q == RLT_BYTE_MAX);
    capture = ticks.lfo_fall && capture_en_q && timer_irq_enable;
  end

  // counter and reload bytes
  always_comb begin
    count_lo_d = count_lo_q;
    count_hi_d = count_hi_q;
    reload_lo_d = reload_lo_q;
    reload_hi_d = reload_hi_q;
    // software writes, overridden below by hardware loads
    if (sfr_wr) begin
      if (sfr_addr == RLT_ADDR_COUNT_LO) begin
        count_lo_d = sfr_wdata;
      end else if (sfr_addr == RLT_ADDR_COUNT_HI) begin
        count_hi_d = sfr_wdata;
      end else if (sfr_addr == RLT_ADDR_RELOAD_LO) begin
        reload_lo_d = sfr_wdata;
      end else if (sfr_addr == RLT_ADDR_RELOAD_HI) begin
        reload_hi_d = sfr_wdata;
      end
    end
    if (split_q) begin
      if (step_lo && !(sfr_wr && sfr_addr == RLT_ADDR_COUNT_LO)) begin
        count_lo_d = wrap_lo ? reload_lo_q : count_lo_q + 8'h01;
      end else if (wrap_lo) begin
        count_lo_d = reload_lo_q;
      end
      if (step_hi && !(sfr_wr && sfr_addr == RLT_ADDR_COUNT_HI)) begin
        count_hi_d = wrap_hi ? reload_hi_q : count_hi_q + 8'h01;
      end else if (wrap_hi) begin
        count_hi_d = reload_hi_q;
      end
    end else if (step_lo) begin
      if (count_word == RLT_WORD_MAX) begin
        count_lo_d = reload_lo_q;
        count_hi_d = reload_hi_q;
      end else begin
        // a plain increment yields to a software byte write
        if (!(sfr_wr && sfr_addr == RLT_ADDR_COUNT_LO)) begin
          count_lo_d = count_lo_q + 8'h01;
        end
        if (wrap_lo && !(sfr_wr && sfr_addr == RLT_ADDR_COUNT_HI)) begin
          count_hi_d = count_hi_q + 8'h01;
        end
      end
    end
    // copy running count into reload pair
    if (capture) begin
      reload_lo_d = count_lo_q;
      reload_hi_d = count_hi_q;
    end
  end

  // control register
  always_comb begin
    high_flag_d = high_flag_q;
    low_flag_d = low_flag_q;
    low_irq_en_d = low_irq_en_q;
    capture_en_d = capture_en_q;
    split_d = split_q;
    run_d = run_q;
    ext_sel_d = ext_sel_q;
    // flags cleared only by software write
    if (sfr_wr && sfr_addr == RLT_ADDR_CTRL) begin
      high_flag_d = sfr_wdata[RLT_BIT_HIGH_FLAG];
      low_flag_d = sfr_wdata[RLT_BIT_LOW_FLAG];
      low_irq_en_d = sfr_wdata[RLT_BIT_LOW_IRQ_EN];
      capture_en_d = sfr_wdata[RLT_BIT_CAPTURE_EN];
      split_d = sfr_wdata[RLT_BIT_SPLIT];
      run_d = sfr_wdata[RLT_BIT_RUN];
      ext_sel_d = sfr_wdata[RLT_BIT_EXT_SEL];
    end
    // high flag on high byte wrap; set beats a same-cycle clear
    if (wrap_hi) begin
      high_flag_d = 1'b1;
    end
    if (wrap_lo) begin
      low_flag_d = 1'b1;
    end
  end

  // read data and interrupt request
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_rd) begin
      if (sfr_addr == RLT_ADDR_CTRL) begin
        rdata_d = ctrl_view;
      end else if (sfr_addr == RLT_ADDR_RELOAD_LO) begin
        rdata_d = reload_lo_q;
      end else if (sfr_addr == RLT_ADDR_RELOAD_HI) begin
        rdata_d = reload_hi_q;
      end else if (sfr_addr == RLT_ADDR_COUNT_LO) begin
        rdata_d = count_lo_q;
      end else if (sfr_addr == RLT_ADDR_COUNT_HI) begin
        rdata_d = count_hi_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
    // high overflow request, low request gated by its enable
    irq_d = timer_irq_enable && (high_flag_q || (low_irq_en_q && low_flag_q));
    irq_d = irq_d || capture;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_flag_q <= RLT_CTRL_RESET[RLT_BIT_HIGH_FLAG];
      low_flag_q <= RLT_CTRL_RESET[RLT_BIT_LOW_FLAG];
      low_irq_en_q <= RLT_CTRL_RESET[RLT_BIT_LOW_IRQ_EN];
      capture_en_q <= RLT_CTRL_RESET[RLT_BIT_CAPTURE_EN];
      split_q <= RLT_CTRL_RESET[RLT_BIT_SPLIT];
      run_q <= RLT_CTRL_RESET[RLT_BIT_RUN];
      ext_sel_q <= RLT_CTRL_RESET[RLT_BIT_EXT_SEL];
      count_lo_q <= RLT_BYTE_RESET;
      count_hi_q <= RLT_BYTE_RESET;
      reload_lo_q <= RLT_BYTE_RESET;
      reload_hi_q <= RLT_BYTE_RESET;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      high_flag_q <= high_flag_d;
      low_flag_q <= low_flag_d;
      low_irq_en_q <= low_irq_en_d;
      capture_en_q <= capture_en_d;
      split_q <= split_d;
      run_q <= run_d;
      ext_sel_q <= ext_sel_d;
      count_lo_q <= count_lo_d;
      count_hi_q <= count_hi_d;
      reload_lo_q <= reload_lo_d;
      reload_hi_q <= reload_hi_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign timer_irq = irq_q;
endmodule
`default_nettype wire

// ---- verif/rlt_timer_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module rlt_timer_asserts
  import rlt_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic rst_n, // reset
  input wire logic [7:0] sfr_addr, // address
  input wire logic sfr_wr, // write
  input wire logic sfr_rd, // read
  input wire logic [7:0] sfr_wdata, // wdata
  input wire logic [7:0] sfr_rdata, // rdata
  input wire logic timer_irq_enable, // irq enable
  input wire logic high_byte_clock_select, // hi select
  input wire logic low_byte_clock_select, // lo select
  input wire logic ext_clk, // ext clock
  input wire logic lfo_out, // lfo
  input wire logic timer_irq // irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic rd_q;
  logic ie_q;
  logic [7:0] ad_q;
  logic rc;
  // read data and irq both reflect the register state before the read edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      ie_q <= 1'b0;
      ad_q <= 8'h00;
    end else begin
      rd_q <= sfr_rd;
      ie_q <= timer_irq_enable;
      ad_q <= sfr_addr;
    end
  end
  assign rc = rd_q && (ad_q == RLT_ADDR_CTRL);
  a_rdata_hold: assert property (!rd_q |-> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd_q && !(ad_q inside {8'hc8, [8'hca:8'hcd]}) |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_bit1_zero: assert property (rc |-> !sfr_rdata[1])
    else $error("control bit 1 read as one");
  a_irq_needs_en: assert property (timer_irq |-> ie_q)
    else $error("irq without enable");
  a_high_irq: assert property (rc && sfr_rdata[7] && ie_q |-> timer_irq)
    else $error("high flag gave no irq");
  a_low_irq: assert property (rc && sfr_rdata[6] && sfr_rdata[5] && ie_q |-> timer_irq)
    else $error("low flag with enable gave no irq");
  a_low_gated: assert property (rc && sfr_rdata[7:4] == 4'b0100 |-> !timer_irq)
    else $error("low flag irq while masked");
  a_quiet_flags: assert property (rc && sfr_rdata[7:6] == 2'b00 && !sfr_rdata[4] |-> !timer_irq)
    else $error("irq without flag");
  c_high: cover property (rc && sfr_rdata[7]);
  c_low: cover property (rc && sfr_rdata[6] && !sfr_rdata[7]);
  c_irq: cover property ($rose(timer_irq));
endmodule
`default_nettype wire

// ---- verif/rlt_timer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module rlt_timer_test;
  import rlt_pkg::*;
  logic sys_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, ie = 0, hsel = 0, lsel = 0, ext_clk = 0, lfo_out = 1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, v;
  logic timer_irq;
  logic [7:0] sfr_rdata;
  logic [7:0] al [6] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc9};
  int mismatches = 0, n_compared = 0;
  rlt_timer u_rlt_timer (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_irq_enable(ie),
    .high_byte_clock_select(hsel), .low_byte_clock_select(lsel), .ext_clk(ext_clk),
    .lfo_out(lfo_out), .timer_irq(timer_irq));
  initial forever #2 sys_clk = ~sys_clk;
  // external oscillator, one quarter of the system clock rate
  initial forever #8 ext_clk = ~ext_clk;
  task chk(input logic [7:0] s, input logic [7:0] e, input string n);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_wr <= 1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge sys_clk);
    sfr_wr <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    sfr_rd <= 1;
    sfr_addr <= a;
    @(posedge sys_clk);
    sfr_rd <= 0;
    #1 v = sfr_rdata;
  endtask
  task run_rate(input logic [7:0] c, input int n);
    // stop the timer first so no wrap or reload can override the count writes
    wr(8'hc8, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hcc, 8'h00);
    wr(8'hc8, c);
    repeat (n) @(posedge sys_clk);
    wr(8'hc8, 8'h00);
    rd(8'hcc);
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1;
    foreach (al[i]) begin
      rd(al[i]);
      chk(v, 8'h00, "reset value");
    end
    wr(8'hc8, 8'h02);
    rd(8'hc8);
    chk(v, 8'h00, "unused bit");
    ie <= 1;
    lsel <= 1;
    wr(8'hca, 8'h34);
    wr(8'hcb, 8'h12);
    wr(8'hcd, 8'hff);
    wr(8'hcc, 8'hfe);
    wr(8'hc8, 8'h04);
    repeat (8) @(posedge sys_clk);
    rd(8'hc8);
    chk(v, 8'hc4, "word wrap flags");
    chk({7'h0, timer_irq}, 8'h01, "word irq");
    wr(8'hc8, 8'h00);
    rd(8'hcd);
    chk(v, 8'h12, "reloaded high");
    wr(8'hca, 8'hf0);
    wr(8'hcb, 8'h55);
    wr(8'hcd, 8'h55);
    wr(8'hcc, 8'hf0);
    wr(8'hc8, 8'h08);
    repeat (40) @(posedge sys_clk);
    rd(8'hc8);
    chk(v, 8'h48, "split low flag");
    chk({7'h0, timer_irq}, 8'h00, "masked low irq");
    rd(8'hcd);
    chk(v, 8'h55, "high held");
    wr(8'hc8, 8'h28);
    repeat (20) @(posedge sys_clk);
    chk({7'h0, timer_irq}, 8'h01, "low irq");
    hsel <= 1;
    wr(8'hcd, 8'hf8);
    wr(8'hc8, 8'h0c);
    repeat (20) @(posedge sys_clk);
    rd(8'hc8);
    chk(v & 8'h80, 8'h80, "split high flag");
    lsel <= 0;
    run_rate(8'h04, 120);
    chk({7'h0, v inside {[8'h09:8'h0c]}}, 8'h01, "div12 rate");
    run_rate(8'h05, 400);
    chk({7'h0, v inside {[8'h0b:8'h0e]}}, 8'h01, "ext8 rate");
    wr(8'hcd, 8'hab);
    wr(8'hcc, 8'hcd);
    wr(8'hc8, 8'h10);
    lfo_out <= 0;
    v = 8'h00;
    repeat (12) begin
      @(posedge sys_clk);
      #1 if (timer_irq === 1'b1) v = 8'h01;
    end
    chk(v, 8'h01, "capture irq");
    rd(8'hca);
    chk(v, 8'hcd, "capture low");
    rd(8'hcb);
    chk(v, 8'hab, "capture high");
    wrap_up;
  end
endmodule
bind rlt_timer rlt_timer_asserts u_rlt_timer_asserts (.*);
`default_nettype wire
